// [perf_hint_pkg.sv]
/*
  Shared constants for the per-thread performance hint registers:
  register addresses, field layout, reset values and timing counts.
  Assumes a 250 MHz core clock; all users refer to names with pkg::.
*/
package perf_hint_pkg;

  // register addresses on the model-specific register port
  localparam logic [11:0] ADDR_CAP = 12'h771;
  localparam logic [11:0] ADDR_REQ = 12'h774;

  // capability word layout
  localparam int CAP_HIGH_LO = 0;
  localparam int CAP_GUAR_LO = 8;
  localparam int CAP_EFF_LO = 16;
  localparam int CAP_LOW_LO = 24;
  localparam int LVL_W = 8;

  // request word layout
  localparam int MIN_LO = 0;
  localparam int MAX_LO = 8;
  localparam int DES_LO = 16;
  localparam int PREF_LO = 24;
  localparam int WIN_LO = 32;
  localparam int WIN_W = 10;
  localparam int WIN_MANT_W = 7;
  localparam int WIN_EXP_LO = 39;
  localparam int WIN_EXP_W = 3;
  localparam int PKG_CTL_BIT = 42;
  localparam int VALID_HI = 63;

  // implemented-bit masks; bits 58:43 are never stored
  localparam logic [63:0] MASK_BASE = 64'h0000_0400_00FF_FFFF;
  localparam logic [63:0] MASK_PREF = 64'h0000_0000_FF00_0000;
  localparam logic [63:0] MASK_WIN = 64'h0000_03FF_0000_0000;
  localparam logic [63:0] MASK_VALID = 64'hF800_0000_0000_0000;

  // reset values of the request word
  localparam logic [4:0] VALID_RST = 5'h00;
  localparam logic [15:0] RSVD_RST = 16'h0000;
  localparam logic PKG_CTL_RST = 1'b0;
  localparam logic [9:0] WIN_RST = 10'h000;
  localparam logic [7:0] PREF_RST = 8'h80;
  localparam logic [7:0] DES_RST = 8'h00;

  // hint fields in resolution order
  localparam int NFIELD = 5;
  localparam int F_MIN = 0;
  localparam int F_MAX = 1;
  localparam int F_DES = 2;
  localparam int F_PREF = 3;
  localparam int F_WIN = 4;

  // sustain time before a guaranteed-level change is announced
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned SUSTAIN_US = 1000000;
  localparam int unsigned SUSTAIN_CYC = SUSTAIN_US * CLK_MHZ;

  typedef enum logic [0:0] {
    SUS_STABLE = 1'b0,
    SUS_SETTLING = 1'b1
  } sustain_state_e;

endpackage : perf_hint_pkg

// [guar_sustain_filter.sv]
/*
  Guaranteed-level tracker: the level follows its source every cycle,
  and a one-cycle event marks a new value held past the sustain time.
  Assumes the source level comes from logic on the same clock.
*/
module guar_sustain_filter #(
  parameter int unsigned SUSTAIN_CYC = perf_hint_pkg::SUSTAIN_CYC
) (
  input wire logic ref_clk, // core clock
  input wire logic sys_rst, // synchronous reset, high
  input wire logic ce, // clock enable
  input wire logic [7:0] level_in, // current sustainable level
  output logic [7:0] level_r, // level shown in capability word
  output logic evt_r // pulse: sustained change
);

  perf_hint_pkg::sustain_state_e state_r, state_nxt;
  logic [31:0] cnt_r, cnt_nxt;
  logic [7:0] cand_r, cand_nxt;
  logic [7:0] notified_r, notified_nxt;
  logic evt_nxt;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    cand_nxt = cand_r;
    notified_nxt = notified_r;
    evt_nxt = 1'b0;
    if (level_in != cand_r) begin
      // any wobble restarts the wait; short spikes never notify
      cand_nxt = level_in;
      cnt_nxt = '0;
      state_nxt = perf_hint_pkg::SUS_SETTLING;
    end else begin
      case (state_r)
        perf_hint_pkg::SUS_SETTLING: begin
          if (cnt_r == SUSTAIN_CYC) begin
            state_nxt = perf_hint_pkg::SUS_STABLE;
            if (cand_r != notified_r) begin
              evt_nxt = 1'b1;
              notified_nxt = cand_r;
            end
          end else begin
            cnt_nxt = 32'(cnt_r + 32'h1);
          end
        end
        default: state_nxt = perf_hint_pkg::SUS_STABLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_r <= perf_hint_pkg::SUS_STABLE;
      cnt_r <= '0;
      cand_r <= level_in;
      notified_r <= level_in;
      level_r <= level_in;
      evt_r <= 1'b0;
    end else if (ce) begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      cand_r <= cand_nxt;
      notified_r <= notified_nxt;
      level_r <= level_in;
      evt_r <= evt_nxt;
    end
  end

  default clocking cb @(posedge ref_clk iff ce); endclocking
  default disable iff (sys_rst);

  property p_evt_sustained;
    evt_r |-> $past(cnt_r) == SUSTAIN_CYC && level_r == notified_r;
  endproperty
  a_evt_sustained: assert property (p_evt_sustained)
    else $error("change event without sustained level");

  property p_level_follows;
    1'b1 |=> level_r == $past(level_in) && !(evt_r && $past(cnt_r) == 0);
  endproperty
  a_level_follows: assert property (p_level_follows)
    else $error("guaranteed level not tracking its source");

endmodule : guar_sustain_filter

// [perf_hint_request_regs.sv]
/*
  Per-thread performance hint registers: read-only capability word,
  read/write request word, and per-field resolution against the package
  request and platform controller override into clipped hint outputs.
  Assumes feature, level, package and override inputs come from logic
  on the same clock, and one register access per cycle at most.
*/
// Operation
// - capability word: four 8-bit levels, top zero
// - guaranteed level tracks current limits
// - announce guaranteed change only past one second
// - most-efficient tracks workload; max raised to it
// - minimum hint bits 7:0, resets to lowest
// - maximum hint bits 15:8, resets to highest
// - desired hint bits 23:16; zero means autonomous
// - preference bits 31:24, resets to 80h
// - unsupported preference uses energy bias setting
// - window bits 41:32: mantissa, decimal exponent
// - window matters only when desired is zero
// - package control bit 42 selects package request
// - valid bits 63:59 keep thread field locally
// - package control clear ignores valid bits
// - valid bits exist only when feature reports
// - hints clipped for use, reads unclipped
// - unsupported fields read zero, writes dropped
// - equal min and max fixes the level
// - running below minimum hint is allowed
// - exceeding maximum hint is allowed
// - request writes are posted, no acknowledge
// - package request shares the thread field layout
// - override wins for min, max, preference
module perf_hint_request_regs #(
  parameter int unsigned SUSTAIN_CYC = perf_hint_pkg::SUSTAIN_CYC
) (
  input wire logic ref_clk, // core clock, 250 MHz
  input wire logic sys_rst, // synchronous reset, high
  input wire logic ce, // clock enable, freezes state
  input wire logic msr_wr, // register write strobe
  input wire logic msr_rd, // register read strobe
  input wire logic [11:0] msr_addr, // register address
  input wire logic [63:0] msr_wdata, // register write data
  output logic [63:0] rd_data_r, // read data
  output logic rd_valid_r, // pulse: read data valid
  output logic rd_fault_r, // pulse: read of unmapped address
  input wire logic feat_pref_sup, // preference field supported
  input wire logic feat_win_sup, // activity window supported
  input wire logic feat_valid_sup, // per-field valid bits supported
  input wire logic [7:0] lvl_highest, // highest level
  input wire logic [7:0] lvl_lowest, // lowest programmable level
  input wire logic [7:0] lvl_guar_raw, // sustainable level now
  input wire logic [7:0] lvl_most_eff, // most efficient level now
  input wire logic [7:0] energy_bias_setting, // fallback preference
  input wire logic [41:0] package_perf_hint_request, // package hints
  input wire logic [2:0] pco_en, // override on: pref, max, min
  input wire logic [7:0] pco_min, // override minimum
  input wire logic [7:0] pco_max, // override maximum
  input wire logic [7:0] pco_pref, // override preference
  output logic [7:0] res_min_r, // resolved minimum
  output logic [7:0] res_max_r, // resolved maximum
  output logic [7:0] res_des_r, // resolved desired
  output logic [7:0] res_efficiency_pref_r, // resolved preference
  output logic [9:0] res_win_r, // resolved window, raw code
  output logic [6:0] win_mant_r, // window mantissa
  output logic [2:0] win_exp_r, // window power-of-ten exponent
  output logic win_auto_r, // hardware picks window
  output logic autonomous_sel_r, // autonomous target selection
  output logic fixed_level_r, // min equals max: hold level
  output logic [7:0] guar_level_r, // guaranteed level in use
  output logic guar_change_evt_r // pulse: sustained change
);

  localparam int LW = perf_hint_pkg::LVL_W;
  localparam int WW = perf_hint_pkg::WIN_W;
  localparam int WIN_MANT_W_L = perf_hint_pkg::WIN_MANT_W;

  logic [63:0] req_r, req_nxt, mask, req_eff, cap_word;
  logic [63:0] rd_data_nxt;
  logic rd_valid_nxt, rd_fault_nxt;
  logic [7:0] cap_eff_r;
  logic [WW-1:0] thr_f [perf_hint_pkg::NFIELD];
  logic [WW-1:0] pkg_f [perf_hint_pkg::NFIELD];
  logic [WW-1:0] pco_f [perf_hint_pkg::NFIELD];
  logic [WW-1:0] rsv_f [perf_hint_pkg::NFIELD];
  logic [perf_hint_pkg::NFIELD-1:0] pco_on, use_pkg;
  logic [7:0] min_nxt, max_nxt, des_nxt, pref_nxt, max_tmp;
  logic [WW-1:0] win_nxt;

  function automatic logic [63:0] sup_mask(input logic p, input logic w,
                                          input logic v);
    logic [63:0] m;
    m = perf_hint_pkg::MASK_BASE;
    if (p) m = m | perf_hint_pkg::MASK_PREF;
    if (w) m = m | perf_hint_pkg::MASK_WIN;
    if (v) m = m | perf_hint_pkg::MASK_VALID;
    return m;
  endfunction : sup_mask

  function automatic logic [7:0] clamp(input logic [7:0] v,
                                       input logic [7:0] lo,
                                       input logic [7:0] hi);
    logic [7:0] c;
    c = v;
    if (v < lo) c = lo;
    if (v > hi) c = hi;
    return c;
  endfunction : clamp

  assign mask = sup_mask(feat_pref_sup, feat_win_sup, feat_valid_sup);
  assign req_eff = req_r & mask;

  assign cap_word = {32'h0000_0000, lvl_lowest, cap_eff_r, guar_level_r,
                     lvl_highest};

  guar_sustain_filter #(
    .SUSTAIN_CYC(SUSTAIN_CYC)
  ) u_guar (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .level_in(lvl_guar_raw),
    .level_r(guar_level_r),
    .evt_r(guar_change_evt_r)
  );

  always_comb begin
    req_nxt = req_r;
    rd_data_nxt = '0;
    rd_valid_nxt = 1'b0;
    rd_fault_nxt = 1'b0;
    if (msr_wr && msr_addr == perf_hint_pkg::ADDR_REQ) begin
      req_nxt = (msr_wdata & mask) | (req_r & ~mask);
    end
    if (msr_rd) begin
      rd_valid_nxt = 1'b1;
      case (msr_addr)
        perf_hint_pkg::ADDR_CAP: rd_data_nxt = cap_word;
        perf_hint_pkg::ADDR_REQ: rd_data_nxt = req_eff;
        default: rd_fault_nxt = 1'b1;
      endcase
    end
  end

  assign pkg_f[perf_hint_pkg::F_MIN] =
    WW'(package_perf_hint_request[perf_hint_pkg::MIN_LO +: LW]);
  assign pkg_f[perf_hint_pkg::F_MAX] =
    WW'(package_perf_hint_request[perf_hint_pkg::MAX_LO +: LW]);
  assign pkg_f[perf_hint_pkg::F_DES] =
    WW'(package_perf_hint_request[perf_hint_pkg::DES_LO +: LW]);
  assign pkg_f[perf_hint_pkg::F_PREF] =
    WW'(package_perf_hint_request[perf_hint_pkg::PREF_LO +: LW]);
  assign pkg_f[perf_hint_pkg::F_WIN] =
    package_perf_hint_request[perf_hint_pkg::WIN_LO +: WW];

  assign thr_f[perf_hint_pkg::F_MIN] =
    WW'(req_eff[perf_hint_pkg::MIN_LO +: LW]);
  assign thr_f[perf_hint_pkg::F_MAX] =
    WW'(req_eff[perf_hint_pkg::MAX_LO +: LW]);
  assign thr_f[perf_hint_pkg::F_DES] =
    WW'(req_eff[perf_hint_pkg::DES_LO +: LW]);
  assign thr_f[perf_hint_pkg::F_PREF] = feat_pref_sup ?
    WW'(req_eff[perf_hint_pkg::PREF_LO +: LW]) : WW'(energy_bias_setting);
  assign thr_f[perf_hint_pkg::F_WIN] = req_eff[perf_hint_pkg::WIN_LO +: WW];

  // desired and window have no override path
  assign pco_on = {1'b0, pco_en[2], 1'b0, pco_en[1], pco_en[0]};
  assign pco_f[perf_hint_pkg::F_MIN] = WW'(pco_min);
  assign pco_f[perf_hint_pkg::F_MAX] = WW'(pco_max);
  assign pco_f[perf_hint_pkg::F_DES] = '0;
  assign pco_f[perf_hint_pkg::F_PREF] = WW'(pco_pref);
  assign pco_f[perf_hint_pkg::F_WIN] = '0;

  for (genvar f = 0; f < perf_hint_pkg::NFIELD; f++) begin : g_field
    assign use_pkg[f] = req_eff[perf_hint_pkg::PKG_CTL_BIT] &
                        ~req_eff[perf_hint_pkg::VALID_HI - f];
    assign rsv_f[f] = pco_on[f] ? pco_f[f] :
                      (use_pkg[f] ? pkg_f[f] : thr_f[f]);
  end

  always_comb begin
    min_nxt = clamp(rsv_f[perf_hint_pkg::F_MIN][LW-1:0], lvl_lowest,
                    lvl_highest);
    max_tmp = rsv_f[perf_hint_pkg::F_MAX][LW-1:0];
    if (max_tmp < lvl_most_eff) max_tmp = lvl_most_eff;
    max_nxt = clamp(max_tmp, lvl_lowest, lvl_highest);
    des_nxt = rsv_f[perf_hint_pkg::F_DES][LW-1:0];
    if (des_nxt != 8'h00) des_nxt = clamp(des_nxt, lvl_lowest, lvl_highest);
    pref_nxt = rsv_f[perf_hint_pkg::F_PREF][LW-1:0];
    win_nxt = (des_nxt == 8'h00) ? rsv_f[perf_hint_pkg::F_WIN] : '0;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      req_r <= {perf_hint_pkg::VALID_RST, perf_hint_pkg::RSVD_RST,
                perf_hint_pkg::PKG_CTL_RST, perf_hint_pkg::WIN_RST,
                perf_hint_pkg::PREF_RST, perf_hint_pkg::DES_RST,
                lvl_highest, lvl_lowest};
      rd_data_r <= '0;
      rd_valid_r <= 1'b0;
      rd_fault_r <= 1'b0;
      cap_eff_r <= lvl_most_eff;
    end else if (ce) begin
      req_r <= req_nxt;
      rd_data_r <= rd_data_nxt;
      rd_valid_r <= rd_valid_nxt;
      rd_fault_r <= rd_fault_nxt;
      cap_eff_r <= lvl_most_eff;
    end
  end

  // hints only: the selector may go below min or above max
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      res_min_r <= '0;
      res_max_r <= '0;
      res_des_r <= '0;
      res_efficiency_pref_r <= '0;
      res_win_r <= '0;
      win_mant_r <= '0;
      win_exp_r <= '0;
      win_auto_r <= 1'b1;
      autonomous_sel_r <= 1'b1;
      fixed_level_r <= 1'b0;
    end else if (ce) begin
      res_min_r <= min_nxt;
      res_max_r <= max_nxt;
      res_des_r <= des_nxt;
      res_efficiency_pref_r <= pref_nxt;
      res_win_r <= win_nxt;
      win_mant_r <= win_nxt[WIN_MANT_W_L-1:0];
      win_exp_r <= win_nxt[WW-1 -: perf_hint_pkg::WIN_EXP_W];
      win_auto_r <= (win_nxt == '0);
      autonomous_sel_r <= (des_nxt == 8'h00);
      fixed_level_r <= (min_nxt == max_nxt);
    end
  end

  default clocking cb @(posedge ref_clk iff ce); endclocking
  default disable iff (sys_rst);

  sequence s_req_write;
    msr_wr && !msr_rd && msr_addr == perf_hint_pkg::ADDR_REQ;
  endsequence
  sequence s_req_read;
    msr_rd && !msr_wr && msr_addr == perf_hint_pkg::ADDR_REQ;
  endsequence

  property p_cap_layout;
    msr_rd && msr_addr == perf_hint_pkg::ADDR_CAP |=> rd_valid_r &&
      rd_data_r[63:32] == 32'h0000_0000 &&
      rd_data_r[31:24] == $past(lvl_lowest) &&
      rd_data_r[7:0] == $past(lvl_highest);
  endproperty
  a_cap_layout: assert property (p_cap_layout)
    else $error("capability word layout wrong");

  property p_req_defaults;
    $past(sys_rst) |-> req_r[7:0] == $past(lvl_lowest) &&
      req_r[15:8] == $past(lvl_highest) && req_r[23:16] == 8'h00 &&
      req_r[31:24] == 8'h80 && req_r[63:32] == 32'h0000_0000;
  endproperty
  a_req_defaults: assert property (p_req_defaults)
    else $error("request word reset value wrong");

  property p_readback;
    logic [63:0] d;
    (s_req_write, d = msr_wdata) ##1 s_req_read |=> rd_valid_r &&
      rd_data_r == (d & mask);
  endproperty
  a_readback: assert property (p_readback)
    else $error("request read does not return written value");

  property p_override_min;
    pco_en[0] && pco_min >= lvl_lowest && pco_min <= lvl_highest
      |=> res_min_r == $past(pco_min);
  endproperty
  a_override_min: assert property (p_override_min)
    else $error("override minimum not applied");

  property p_pkg_desired;
    req_eff[42] && !req_eff[61] && !package_perf_hint_request[23] &&
      package_perf_hint_request[22:16] == 7'h00
      |=> res_des_r == 8'h00 && autonomous_sel_r;
  endproperty
  a_pkg_desired: assert property (p_pkg_desired)
    else $error("package desired value not selected");

  property p_thread_only;
    !req_eff[42] && feat_pref_sup && !pco_en[2]
      |=> res_efficiency_pref_r == $past(req_r[31:24]);
  endproperty
  a_thread_only: assert property (p_thread_only)
    else $error("thread preference not used with package control clear");

  property p_bias_fallback;
    !feat_pref_sup && !req_eff[42] && !pco_en[2]
      |=> res_efficiency_pref_r == $past(energy_bias_setting);
  endproperty
  a_bias_fallback: assert property (p_bias_fallback)
    else $error("energy bias not used as preference");

  property p_window_gate;
    res_des_r != 8'h00 |-> res_win_r == '0 && !autonomous_sel_r;
  endproperty
  a_window_gate: assert property (p_window_gate)
    else $error("window active with explicit desired level");

  // flags update together with min and max on the first edge after release
  property p_fixed;
    1'b1 |=> fixed_level_r == (res_min_r == res_max_r);
  endproperty
  a_fixed: assert property (p_fixed)
    else $error("fixed-level flag disagrees with min and max");

  property p_max_floor;
    lvl_most_eff <= lvl_highest |=> res_max_r >= $past(lvl_most_eff);
  endproperty
  a_max_floor: assert property (p_max_floor)
    else $error("maximum below most efficient level");

endmodule : perf_hint_request_regs

// [perf_hint_request_regs_bench.sv]
/*
  Self-checking bench for the per-thread performance hint registers.
  Assumes the 250 MHz core clock, synchronous high reset and a short
  sustain count; the design carries its own assertions.
*/
module perf_hint_request_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int unsigned SUS = 16;
  logic ref_clk, sys_rst, ce, msr_wr, msr_rd;
  logic [11:0] msr_addr;
  logic [63:0] msr_wdata, rd_data_r, rdv;
  logic rd_valid_r, rd_fault_r, rdf;
  logic feat_pref_sup, feat_win_sup, feat_valid_sup;
  logic [7:0] lvl_highest, lvl_lowest, lvl_guar_raw, lvl_most_eff;
  logic [7:0] energy_bias_setting, pco_min, pco_max, pco_pref;
  logic [41:0] package_perf_hint_request;
  logic [2:0] pco_en;
  logic [7:0] res_min_r, res_max_r, res_des_r, res_efficiency_pref_r;
  logic [9:0] res_win_r;
  logic [6:0] win_mant_r;
  logic [2:0] win_exp_r;
  logic win_auto_r, autonomous_sel_r, fixed_level_r;
  logic [7:0] guar_level_r;
  logic guar_change_evt_r;
  int bad_count = 0;
  int checks_done = 0;

  perf_hint_request_regs #(.SUSTAIN_CYC(SUS)) dut (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .ce(ce), .msr_wr(msr_wr), .msr_rd(msr_rd),
    .msr_addr(msr_addr), .msr_wdata(msr_wdata), .rd_data_r(rd_data_r),
    .rd_valid_r(rd_valid_r), .rd_fault_r(rd_fault_r),
    .feat_pref_sup(feat_pref_sup), .feat_win_sup(feat_win_sup),
    .feat_valid_sup(feat_valid_sup), .lvl_highest(lvl_highest),
    .lvl_lowest(lvl_lowest), .lvl_guar_raw(lvl_guar_raw),
    .lvl_most_eff(lvl_most_eff), .energy_bias_setting(energy_bias_setting),
    .package_perf_hint_request(package_perf_hint_request),
    .pco_en(pco_en), .pco_min(pco_min), .pco_max(pco_max),
    .pco_pref(pco_pref), .res_min_r(res_min_r), .res_max_r(res_max_r),
    .res_des_r(res_des_r), .res_efficiency_pref_r(res_efficiency_pref_r),
    .res_win_r(res_win_r), .win_mant_r(win_mant_r), .win_exp_r(win_exp_r),
    .win_auto_r(win_auto_r), .autonomous_sel_r(autonomous_sel_r),
    .fixed_level_r(fixed_level_r), .guar_level_r(guar_level_r),
    .guar_change_evt_r(guar_change_evt_r));

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [63:0] d);
    @(posedge ref_clk);
    #1;
    msr_wr = 1'b1;
    msr_addr = a;
    msr_wdata = d;
    @(posedge ref_clk);
    #1;
    msr_wr = 1'b0;
  endtask : wr

  // posted write has no answer; resolved hints land two edges later
  task automatic settle;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask : settle

  task automatic rd(input logic [11:0] a);
    @(posedge ref_clk);
    #1;
    msr_rd = 1'b1;
    msr_addr = a;
    @(posedge ref_clk);
    #1;
    msr_rd = 1'b0;
    chk(rd_valid_r, 1'b1);
    rdv = rd_data_r;
    rdf = rd_fault_r;
  endtask : rd

  // read straight after write: readback must already hold the new word
  task automatic wr_rd(input logic [11:0] a, input logic [63:0] d);
    @(posedge ref_clk);
    #1;
    msr_wr = 1'b1;
    msr_addr = a;
    msr_wdata = d;
    @(posedge ref_clk);
    #1;
    msr_wr = 1'b0;
    msr_rd = 1'b1;
    @(posedge ref_clk);
    #1;
    msr_rd = 1'b0;
    chk(rd_valid_r, 1'b1);
    rdv = rd_data_r;
  endtask : wr_rd

  task automatic t_reset_map;
    rd(12'h771);
    chk(rdv, 64'h0000_0000_1040_80F0);
    wr(12'h771, 64'hFFFF_FFFF_FFFF_FFFF);
    rd(12'h771);
    chk(rdv, 64'h0000_0000_1040_80F0);
    rd(12'h774);
    chk(rdv, 64'h0000_0000_8000_F010);
    chk({res_min_r, res_max_r}, 16'h10F0);
    chk({res_des_r, res_efficiency_pref_r}, 16'h0080);
    chk({autonomous_sel_r, win_auto_r}, 2'b11);
    rd(12'h773);
    chk(rdf, 1'b1);
    chk(rdv, 64'h0);
  endtask : t_reset_map

  task automatic t_clip_readback;
    wr(12'h774, 64'hF800_0000_33FF_2005);
    settle();
    rd(12'h774);
    chk(rdv, 64'hF800_0000_33FF_2005);
    chk(res_min_r, 8'h10);
    chk(res_max_r, 8'h40);
    chk(res_des_r, 8'hF0);
    chk(res_efficiency_pref_r, 8'h33);
    chk(autonomous_sel_r, 1'b0);
  endtask : t_clip_readback

  task automatic t_pkg_select;
    wr(12'h774, {5'h00, 16'h0, 1'b1, 10'h0AB, 32'h1150_E020});
    settle();
    chk({res_min_r, res_max_r, res_des_r}, 24'h30C000);
    chk(res_efficiency_pref_r, 8'hA0);
    chk({res_win_r, win_mant_r, win_exp_r}, {10'h085, 7'h05, 3'h1});
    chk({win_auto_r, autonomous_sel_r}, 2'b01);
    wr(12'h774, {5'h1F, 16'h0, 1'b1, 10'h0AB, 32'h1150_E020});
    settle();
    chk({res_min_r, res_max_r, res_des_r}, 24'h20E050);
    chk(res_efficiency_pref_r, 8'h11);
    chk(res_win_r, 10'h000);
    @(posedge ref_clk);
    #1;
    pco_en = 3'b111;
    settle();
    chk({res_min_r, res_max_r}, 16'h1890);
    chk(res_efficiency_pref_r, 8'h77);
    @(posedge ref_clk);
    #1;
    pco_en = 3'b000;
  endtask : t_pkg_select

  task automatic t_fixed_level;
    wr_rd(12'h774, 64'h0000_0000_8000_6060);
    chk(rdv, 64'h0000_0000_8000_6060);
    settle();
    chk({fixed_level_r, res_min_r, res_max_r}, {1'b1, 16'h6060});
    wr(12'h774, 64'h0000_0000_8000_6160);
    settle();
    chk(fixed_level_r, 1'b0);
    // enable low: the write is not taken and hints stay frozen
    @(posedge ref_clk);
    #1;
    ce = 1'b0;
    wr(12'h774, 64'h0000_0000_8000_6060);
    settle();
    chk({fixed_level_r, res_min_r, res_max_r}, {1'b0, 16'h6061});
    ce = 1'b1;
    rd(12'h774);
    chk(rdv, 64'h0000_0000_8000_6160);
  endtask : t_fixed_level

  task automatic t_unsupported;
    @(posedge ref_clk);
    #1;
    feat_pref_sup = 1'b0;
    feat_win_sup = 1'b0;
    feat_valid_sup = 1'b0;
    wr(12'h774, {5'h1F, 16'h0, 1'b0, 10'h3FF, 32'h9900_7050});
    settle();
    rd(12'h774);
    chk(rdv, 64'h0000_0000_0000_7050);
    chk(res_efficiency_pref_r, 8'h2C);
    feat_pref_sup = 1'b1;
    feat_win_sup = 1'b1;
    feat_valid_sup = 1'b1;
  endtask : t_unsupported

  // a short-lived level must restart the sustain count
  task automatic t_guar_change;
    int n;
    @(posedge ref_clk);
    #1;
    lvl_guar_raw = 8'h60;
    repeat (5) begin
      @(posedge ref_clk);
      #1;
      chk(guar_change_evt_r, 1'b0);
    end
    lvl_guar_raw = 8'h70;
    @(posedge ref_clk);
    #1;
    chk(guar_level_r, 8'h70);
    n = 1;
    while (guar_change_evt_r !== 1'b1 && n < 40) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk(n, SUS + 2);
    @(posedge ref_clk);
    #1;
    chk(guar_change_evt_r, 1'b0);
    rd(12'h771);
    chk(rdv[15:8], 8'h70);
  endtask : t_guar_change

  initial begin
    sys_rst = 1'b1;
    ce = 1'b1;
    msr_wr = 1'b0;
    msr_rd = 1'b0;
    msr_addr = 12'h000;
    msr_wdata = 64'h0;
    feat_pref_sup = 1'b1;
    feat_win_sup = 1'b1;
    feat_valid_sup = 1'b1;
    lvl_highest = 8'hF0;
    lvl_lowest = 8'h10;
    lvl_guar_raw = 8'h80;
    lvl_most_eff = 8'h40;
    energy_bias_setting = 8'h2C;
    package_perf_hint_request = {10'h085, 32'hA000_C030};
    pco_en = 3'b000;
    pco_min = 8'h18;
    pco_max = 8'h90;
    pco_pref = 8'h77;
    repeat (5) @(posedge ref_clk);
    #1;
    sys_rst = 1'b0;
    t_reset_map();
    t_clip_readback();
    t_pkg_select();
    t_fixed_level();
    t_unsupported();
    t_guar_change();
    complete_run();
  end

  // whole sequence needs well under a thousand cycles
  initial begin
    #12000;
    bad_count++;
    complete_run();
  end
endmodule : perf_hint_request_regs_bench
